/* rtl/sbs_defs.svh */
// Purpose: Offsets, field positions, codes and reset values
// Assumes: 32-bit register words at byte offsets
// Notes:   Definitions only
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
`define SBS_OFS_SKIP0     8'h00
`define SBS_OFS_SKIP1     8'h04
`define SBS_OFS_SKIP2     8'h08
`define SBS_OFS_BAND      8'h0C
`define SBS_OFS_HYST      8'h10
`define SBS_OFS_LIM_HI    8'h14
`define SBS_OFS_LIM_LO    8'h18
`define SBS_OFS_CTRL      8'h1C
`define SBS_OFS_SLIP_FL   8'h20
`define SBS_OFS_GAIN      8'h24
`define SBS_OFS_METER     8'h28
`define SBS_OFS_STAT      8'h2C
`define SBS_SKIP_IDX      3:2
`define SBS_WORD_LSB      2
`define SBS_MODE_VHZ      3'h3
`define SBS_FB_SENSORLESS 3'h2
`define SBS_SLIP_EN_BIT   19
`define SBS_RST_GAIN      8'h10
`define SBS_IQ_FRAC       12
`define SBS_GAIN_FRAC     8
`define SBS_NBANDS        3
`endif

/* rtl/sbs_pkg.sv */
// Purpose: Types shared by the skip band and slip blocks
// Assumes: 16-bit unsigned speeds
// Notes:   Band limits carry one guard bit
package sbs_pkg;
    localparam int SBS_SW = 16;
    typedef enum logic {
        SBS_BUS_IDLE = 1'b0,
        SBS_BUS_ACK  = 1'b1
    } sbs_bus_st_t;
    typedef struct packed {
        logic              act;
        logic [SBS_SW:0]   lo;
        logic [SBS_SW:0]   hi;
    } sbs_band_t;
endpackage

/* rtl/sbs_slip_filter.sv */
// Purpose: First-order filter of torque current
// Assumes: Gain in 1/256 steps, 0 freezes the filter
// Notes:   Clear forces the filter to zero
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"
module sbs_slip_filter import sbs_pkg::*; #(
    parameter int SW = SBS_SW
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 clear,
    input  wire logic [7:0]           gain,
    input  wire logic signed [SW-1:0] iq_in,
    output logic signed [SW-1:0]      iq_filt
);
    localparam int AW = SW + `SBS_GAIN_FRAC;
    logic signed [AW-1:0]  acc_reg;
    logic signed [SW:0]    diff;
    logic signed [AW+1:0]  step;
    logic signed [AW+1:0]  acc_next;

    assign iq_filt  = acc_reg[AW-1:`SBS_GAIN_FRAC];
    assign diff     = {iq_in[SW-1], iq_in} - {iq_filt[SW-1], iq_filt};
    // Larger gain moves farther toward the input each cycle
    assign step     = diff * $signed({1'b0, gain});
    assign acc_next = {{2{acc_reg[AW-1]}}, acc_reg} + step;

    always_ff @(posedge sys_clk) begin
        if (reset || clear) begin
            acc_reg <= '0;
        end else begin
            acc_reg <= acc_next[AW-1:0];
        end
    end

    a_filt_clear: assert property (@(posedge sys_clk) disable iff (reset)
        clear |=> iq_filt == '0) else $error("filter not cleared");
endmodule
`default_nettype wire

/* rtl/sbs_skip_slip.sv */
// Purpose: Skip band conditioning and slip compensation of speed command
// Assumes: Avalon-MM slave, one wait cycle per access
// Notes:   Unsigned speeds, signed torque current, 1.0 load = 2^12
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"
module sbs_skip_slip import sbs_pkg::*; #(
    parameter int SW = SBS_SW
) (
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic [7:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic [SW-1:0]        speed_cmd,
    input  wire logic [2:0]           motor_ctrl_mode,
    input  wire logic [2:0]           motor_fdbk_sel,
    input  wire logic signed [SW-1:0] torque_current,
    output logic [SW-1:0]             speed_out,
    output logic signed [SW:0]        slip_correction_meter,
    output logic                      skip_active
);
    localparam int NB = `SBS_NBANDS;

    function automatic logic [7:0] word_ofs(input logic [7:0] a);
        return {a[7:`SBS_WORD_LSB], 2'b00};
    endfunction

    function automatic logic [SW:0] ext(input logic [SW-1:0] v);
        return {1'b0, v};
    endfunction

    function automatic logic [31:0] rd16(input logic [SW-1:0] v);
        return {{(32-SW){1'b0}}, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    sbs_bus_st_t           bus_reg;
    logic                  bus_req;
    logic                  wr_go;
    logic [31:0]           rd_mux;
    logic [31:0]           rdata_reg;
    logic [SW-1:0]         skip_ctr_reg [NB];
    logic [SW-1:0]         band_w_reg;
    logic [SW-1:0]         hyst_reg;
    logic [SW-1:0]         lim_hi_reg;
    logic [SW-1:0]         lim_lo_reg;
    logic [31:0]           ctrl_opts_reg;
    logic [SW-1:0]         slip_fl_reg;
    logic [7:0]            slip_gain_reg;

    sbs_band_t             raw   [NB];
    sbs_band_t             mrg   [NB];
    sbs_band_t             band  [NB];
    logic [SW:0]           ctr   [NB];
    logic [NB-1:0]         side_reg;
    logic [NB-1:0]         side_next;
    logic [NB-1:0]         hit_vec;
    logic                  vhz;
    logic [SW-1:0]         skip_spd;
    logic                  slip_on;
    logic signed [SW-1:0]  iq_filt;
    logic signed [2*SW:0]  slip_prod;
    logic signed [SW:0]    corr;
    logic signed [SW+1:0]  out_sum;
    logic [SW-1:0]         out_next;
    logic [SW-1:0]         speed_out_reg;
    logic signed [SW:0]    meter_reg;
    logic                  skip_active_reg;

    assign bus_req         = avs_read || avs_write;
    assign avs_waitrequest = bus_req && (bus_reg == SBS_BUS_IDLE);
    assign wr_go           = avs_write && (bus_reg == SBS_BUS_ACK);
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_reg <= SBS_BUS_IDLE;
        end else if (bus_req && bus_reg == SBS_BUS_IDLE) begin
            bus_reg <= SBS_BUS_ACK;
        end else begin
            bus_reg <= SBS_BUS_IDLE;
        end
    end

    always_comb begin
        unique case (word_ofs(avs_address))
            `SBS_OFS_SKIP0:   rd_mux = rd16(skip_ctr_reg[0]);
            `SBS_OFS_SKIP1:   rd_mux = rd16(skip_ctr_reg[1]);
            `SBS_OFS_SKIP2:   rd_mux = rd16(skip_ctr_reg[2]);
            `SBS_OFS_BAND:    rd_mux = rd16(band_w_reg);
            `SBS_OFS_HYST:    rd_mux = rd16(hyst_reg);
            `SBS_OFS_LIM_HI:  rd_mux = rd16(lim_hi_reg);
            `SBS_OFS_LIM_LO:  rd_mux = rd16(lim_lo_reg);
            `SBS_OFS_CTRL:    rd_mux = ctrl_opts_reg;
            `SBS_OFS_SLIP_FL: rd_mux = rd16(slip_fl_reg);
            `SBS_OFS_GAIN:    rd_mux = {24'h000000, slip_gain_reg};
            `SBS_OFS_METER:   rd_mux = {{(31-SW){meter_reg[SW]}}, meter_reg};
            `SBS_OFS_STAT:    rd_mux = {20'h00000, 1'b0, side_reg, 1'b0, band[2].act,
                                        band[1].act, band[0].act, 2'b00, skip_active_reg, slip_on};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_reg <= 32'h00000000;
        end else if (avs_read && bus_reg == SBS_BUS_IDLE) begin
            rdata_reg <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < NB; i++) begin
                skip_ctr_reg[i] <= '0;
            end
            band_w_reg    <= '0;
            hyst_reg      <= '0;
            lim_hi_reg    <= '1;
            lim_lo_reg    <= '0;
            ctrl_opts_reg <= 32'h00000000;
            slip_fl_reg   <= '0;
            slip_gain_reg <= `SBS_RST_GAIN;
        end else if (wr_go) begin
            unique case (word_ofs(avs_address))
                `SBS_OFS_SKIP0,
                `SBS_OFS_SKIP1,
                `SBS_OFS_SKIP2:   skip_ctr_reg[avs_address[`SBS_SKIP_IDX]] <= avs_writedata[SW-1:0];
                `SBS_OFS_BAND:    band_w_reg    <= avs_writedata[SW-1:0];
                `SBS_OFS_HYST:    hyst_reg      <= avs_writedata[SW-1:0];
                `SBS_OFS_LIM_HI:  lim_hi_reg    <= avs_writedata[SW-1:0];
                `SBS_OFS_LIM_LO:  lim_lo_reg    <= avs_writedata[SW-1:0];
                `SBS_OFS_CTRL:    ctrl_opts_reg <= avs_writedata;
                `SBS_OFS_SLIP_FL: slip_fl_reg   <= avs_writedata[SW-1:0];
                `SBS_OFS_GAIN:    slip_gain_reg <= avs_writedata[7:0];
                default:          ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Band construction, merging and clamping
    always_comb begin
        logic [SW:0]   half;
        logic [SW:0]   c;
        logic [SW+1:0] s;
        half = {2'b00, band_w_reg[SW-1:1]};
        c    = '0;
        s    = '0;
        for (int i = 0; i < NB; i++) begin
            c          = ext(skip_ctr_reg[i]);
            raw[i].act = 1'b1;
            raw[i].lo  = (c > half) ? c - half : '0;
            raw[i].hi  = c + half;
        end
        mrg = raw;
        for (int p = 0; p < NB - 1; p++) begin
            for (int i = 0; i < NB; i++) begin
                for (int j = 0; j < NB; j++) begin
                    if (i != j && mrg[i].hi >= mrg[j].lo && mrg[j].hi >= mrg[i].lo) begin
                        mrg[i].lo = (mrg[j].lo < mrg[i].lo) ? mrg[j].lo : mrg[i].lo;
                        mrg[i].hi = (mrg[j].hi > mrg[i].hi) ? mrg[j].hi : mrg[i].hi;
                    end
                end
            end
        end
        for (int i = 0; i < NB; i++) begin
            band[i].act = !(mrg[i].lo > ext(lim_hi_reg) || mrg[i].hi < ext(lim_lo_reg));
            band[i].hi  = (mrg[i].hi > ext(lim_hi_reg)) ? ext(lim_hi_reg) : mrg[i].hi;
            band[i].lo  = (mrg[i].lo < ext(lim_lo_reg)) ? ext(lim_lo_reg) : mrg[i].lo;
            s           = {1'b0, band[i].lo} + {1'b0, band[i].hi};
            ctr[i]      = s[SW+1:1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Side decision with hysteresis and output selection
    assign vhz = (motor_ctrl_mode == `SBS_MODE_VHZ);

    always_comb begin
        logic [SW:0] cm;
        logic [SW:0] h;
        cm = ext(speed_cmd);
        h  = ext(hyst_reg);
        for (int i = 0; i < NB; i++) begin
            if (cm > band[i].hi) begin
                side_next[i] = 1'b1;
            end else if (cm < band[i].lo) begin
                side_next[i] = 1'b0;
            end else if (cm >= ctr[i] + h) begin
                side_next[i] = 1'b1;
            end else if (cm + h < ctr[i]) begin
                side_next[i] = 1'b0;
            end else begin
                side_next[i] = side_reg[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            side_reg <= '0;
        end else begin
            side_reg <= vhz ? side_next : '0;
        end
    end

    always_comb begin
        skip_spd = speed_cmd;
        for (int i = NB - 1; i >= 0; i--) begin
            hit_vec[i] = vhz && band[i].act && ext(speed_cmd) >= band[i].lo
                         && ext(speed_cmd) <= band[i].hi;
            if (hit_vec[i]) begin
                skip_spd = side_next[i] ? band[i].hi[SW-1:0] : band[i].lo[SW-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Slip compensation
    assign slip_on = ctrl_opts_reg[`SBS_SLIP_EN_BIT]
                     && (vhz || motor_fdbk_sel == `SBS_FB_SENSORLESS);

    sbs_slip_filter #(.SW(SW)) u_filt (
        .sys_clk (sys_clk),
        .reset   (reset),
        .clear   (!slip_on),
        .gain    (slip_gain_reg),
        .iq_in   (torque_current),
        .iq_filt (iq_filt)
    );

    assign slip_prod = $signed({1'b0, slip_fl_reg}) * iq_filt;
    assign corr      = slip_on ? slip_prod[`SBS_IQ_FRAC+SW:`SBS_IQ_FRAC] : '0;
    assign out_sum   = $signed({2'b00, skip_spd}) + {corr[SW], corr};

    always_comb begin
        if (out_sum[SW+1]) begin
            out_next = '0;
        end else if (out_sum[SW]) begin
            out_next = '1;
        end else begin
            out_next = out_sum[SW-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            speed_out_reg   <= '0;
            meter_reg       <= '0;
            skip_active_reg <= 1'b0;
        end else begin
            speed_out_reg   <= out_next;
            meter_reg       <= corr;
            skip_active_reg <= |hit_vec;
        end
    end

    assign speed_out             = speed_out_reg;
    assign slip_correction_meter = meter_reg;
    assign skip_active           = skip_active_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_mode_bypass: assert property (@(posedge sys_clk) disable iff (reset)
        !vhz |-> skip_spd == speed_cmd) else $error("skip applied outside mode");
    a_upper_pick: assert property (@(posedge sys_clk) disable iff (reset)
        vhz && band[0].act && hyst_reg == '0 && ext(speed_cmd) >= ctr[0]
        && ext(speed_cmd) <= band[0].hi |-> skip_spd == band[0].hi[SW-1:0])
        else $error("upper limit not chosen");
    a_lower_pick: assert property (@(posedge sys_clk) disable iff (reset)
        vhz && band[0].act && hyst_reg == '0 && ext(speed_cmd) < ctr[0]
        && ext(speed_cmd) >= band[0].lo |-> skip_spd == band[0].lo[SW-1:0])
        else $error("lower limit not chosen");
    a_outside_pass: assert property (@(posedge sys_clk) disable iff (reset)
        hit_vec == '0 |-> skip_spd == speed_cmd) else $error("speed altered outside bands");
    a_merge_join: assert property (@(posedge sys_clk) disable iff (reset)
        raw[0].hi >= raw[1].lo && raw[1].hi >= raw[0].lo |-> mrg[0] == mrg[1])
        else $error("overlapping bands not merged");
    a_clamp_hi: assert property (@(posedge sys_clk) disable iff (reset)
        band[2].act |-> band[2].hi <= ext(lim_hi_reg)) else $error("band above limit");
    a_band_off: assert property (@(posedge sys_clk) disable iff (reset)
        mrg[1].lo > ext(lim_hi_reg) |-> !band[1].act && !hit_vec[1])
        else $error("out of range band active");
    a_hyst_hold: assert property (@(posedge sys_clk) disable iff (reset)
        vhz && $past(vhz) && hit_vec[0] && $stable(speed_cmd) && $stable(band[0])
        |-> side_next[0] == $past(side_next[0])) else $error("side toggled at steady command");
    a_slip_off: assert property (@(posedge sys_clk) disable iff (reset)
        !slip_on |=> slip_correction_meter == '0 && speed_out == $past(skip_spd))
        else $error("slip added while off");
    a_slip_mode: assert property (@(posedge sys_clk) disable iff (reset)
        !vhz && motor_fdbk_sel != `SBS_FB_SENSORLESS |-> !slip_on) else $error("slip in wrong mode");
    a_band_width: assert property (@(posedge sys_clk) disable iff (reset)
        raw[0].hi == ext(skip_ctr_reg[0]) + ext({1'b0, band_w_reg[SW-1:1]}))
        else $error("upper band edge wrong");
    a_band_lo: assert property (@(posedge sys_clk) disable iff (reset)
        ext(skip_ctr_reg[1]) > ext({1'b0, band_w_reg[SW-1:1]})
        |-> raw[1].lo == ext(skip_ctr_reg[1]) - ext({1'b0, band_w_reg[SW-1:1]}))
        else $error("lower band edge wrong");
    a_center_mid: assert property (@(posedge sys_clk) disable iff (reset)
        band[0].act |-> ctr[0] >= band[0].lo && ctr[0] <= band[0].hi)
        else $error("center outside its band");
    a_clamp_lo: assert property (@(posedge sys_clk) disable iff (reset)
        band[1].act |-> band[1].lo >= ext(lim_lo_reg)) else $error("band below limit");
    a_side_clear: assert property (@(posedge sys_clk) disable iff (reset)
        !vhz |=> side_reg == '0) else $error("side state kept outside mode");
    a_bypass_out: assert property (@(posedge sys_clk) disable iff (reset)
        !vhz && !slip_on |=> speed_out == $past(speed_cmd)) else $error("command altered outside mode");
    a_skip_flag: assert property (@(posedge sys_clk) disable iff (reset)
        |hit_vec |=> skip_active) else $error("skip flag not raised");
    a_slip_zero: assert property (@(posedge sys_clk) disable iff (reset)
        iq_filt == '0 |-> corr == '0) else $error("correction without load");
    a_slip_gate: assert property (@(posedge sys_clk) disable iff (reset)
        !ctrl_opts_reg[`SBS_SLIP_EN_BIT] |-> corr == '0) else $error("slip added while disabled");
    a_meter_added: assert property (@(posedge sys_clk) disable iff (reset)
        !out_sum[SW+1] && !out_sum[SW]
        |=> ext(speed_out) == ext($past(skip_spd)) + slip_correction_meter)
        else $error("meter differs from added correction");
    c_upper: cover property (@(posedge sys_clk) disable iff (reset) hit_vec[0] && side_next[0]);
    c_lower: cover property (@(posedge sys_clk) disable iff (reset) hit_vec[0] && !side_next[0]);
    c_merged: cover property (@(posedge sys_clk) disable iff (reset) mrg[0] != raw[0]);
    c_slip: cover property (@(posedge sys_clk) disable iff (reset) slip_on && corr > 0);
    c_hold: cover property (@(posedge sys_clk) disable iff (reset) hit_vec[0] && hyst_reg != '0);
endmodule
`default_nettype wire

/* tb/sbs_ramp_model.sv */
// Purpose: Speed ramp that feeds the speed command
// Assumes: A step of FFFF jumps to the target at once
// Notes:   Behavioural model of the far side
`timescale 1ns/1ps
`default_nettype none
module sbs_ramp_model (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [15:0] target,
    input  wire logic [15:0] step,
    output logic [15:0]      speed_cmd
);
    // Moves toward the target by at most one step per cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            speed_cmd <= 16'h0000;
        end else if (speed_cmd < target) begin
            speed_cmd <= (target - speed_cmd > step) ? speed_cmd + step : target;
        end else if (speed_cmd > target) begin
            speed_cmd <= (speed_cmd - target > step) ? speed_cmd - step : target;
        end
    end
endmodule
`default_nettype wire

/* tb/skip_band_slip_comp_test.sv */
// Purpose: Self-checking bench of skip bands and slip correction
// Assumes: One wait cycle per bus access
// Notes:   Speed results compared through a queue of notes
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.svh"
module skip_band_slip_comp_test;
    logic               sys_clk;
    logic               reset;
    logic [7:0]         avs_address;
    logic               avs_read;
    logic               avs_write;
    logic [31:0]        avs_writedata;
    logic [31:0]        avs_readdata;
    logic               avs_waitrequest;
    logic [15:0]        target;
    logic [15:0]        step;
    logic [15:0]        speed_cmd;
    logic [2:0]         mode;
    logic [2:0]         fdbk;
    logic signed [15:0] torque;
    logic [15:0]        speed_out;
    logic signed [16:0] meter;
    logic               skip_active;
    logic [31:0]        rd;
    logic [31:0]        rng_state;
    logic [15:0]        exp_q[$];
    logic [7:0]         rst_ofs[12];
    logic [31:0]        rst_val[12];
    int                 n_fail;
    int                 checked;
    int                 cycles;
    int                 dwell;

    sbs_ramp_model ramp (.sys_clk(sys_clk), .reset(reset), .target(target), .step(step), .speed_cmd(speed_cmd));
    sbs_skip_slip dut (
        .sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .speed_cmd(speed_cmd), .motor_ctrl_mode(mode),
        .motor_fdbk_sel(fdbk), .torque_current(torque), .speed_out(speed_out),
        .slip_correction_meter(meter), .skip_active(skip_active)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (n_fail == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic drive(input logic [15:0] t, input logic [15:0] e);
        @(posedge sys_clk);
        target <= t;
        repeat (5) @(posedge sys_clk);
        exp_q.push_back(e);
    endtask

    function automatic logic [31:0] in_rng(input logic signed [16:0] v, input logic signed [16:0] lo,
                                           input logic signed [16:0] hi);
        return {31'h0, (v >= lo) && (v <= hi)};
    endfunction

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    // Oldest note against the settled speed output
    always @(negedge sys_clk) begin
        if (exp_q.size() != 0) begin
            check({16'h0000, speed_out}, {16'h0000, exp_q.pop_front()});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        target = 16'h0000;
        step = 16'hFFFF;
        mode = 3'h0;
        fdbk = 3'h0;
        torque = 16'sh0000;
        n_fail = 0;
        checked = 0;
        cycles = 0;
        rng_state = 32'h00000039;
        rst_ofs = '{`SBS_OFS_SKIP0, `SBS_OFS_SKIP1, `SBS_OFS_SKIP2, `SBS_OFS_BAND, `SBS_OFS_HYST, `SBS_OFS_LIM_HI,
                    `SBS_OFS_LIM_LO, `SBS_OFS_CTRL, `SBS_OFS_SLIP_FL, `SBS_OFS_GAIN, `SBS_OFS_METER, 8'h30};
        rst_val = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000FFFF, 32'h0, 32'h0, 32'h0, 32'h00000010, 32'h0, 32'h0};
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        bus(1'b1, `SBS_OFS_METER, 32'h00001234);
        bus(1'b1, 8'h30, 32'h00005678);
        for (int i = 0; i < 12; i++) begin
            bus(1'b0, rst_ofs[i], 32'h0);
            check(rd, rst_val[i]);
        end
        bus(1'b1, `SBS_OFS_SKIP0, 32'h000003E8);
        bus(1'b1, `SBS_OFS_SKIP1, 32'h00001F40);
        bus(1'b1, `SBS_OFS_SKIP2, 32'h00002328);
        bus(1'b1, `SBS_OFS_BAND, 32'h000000C8);
        bus(1'b0, `SBS_OFS_SKIP1, 32'h0);
        check(rd, 32'h00001F40);
        for (int i = 0; i < 16; i++) begin
            rng_state = xs(rng_state);
            drive(rng_state[15:0], rng_state[15:0]);
        end
        drive(16'h041A, 16'h041A);
        @(posedge sys_clk);
        mode <= `SBS_MODE_VHZ;
        drive(16'h041A, 16'h044C);
        check({31'h0, skip_active}, 32'h1);
        drive(16'h03E8, 16'h044C);
        drive(16'h03E7, 16'h0384);
        drive(16'h0384, 16'h0384);
        drive(16'h044C, 16'h044C);
        drive(16'h044D, 16'h044D);
        drive(16'h1F40, 16'h1FA4);
        drive(16'h0320, 16'h0320);
        @(posedge sys_clk);
        step <= 16'h000A;
        target <= 16'h0514;
        dwell = 0;
        repeat (80) begin
            @(posedge sys_clk);
            if (skip_active === 1'b1) dwell++;
        end
        check(dwell, 32'h00000015);
        step <= 16'hFFFF;
        drive(16'h0514, 16'h0514);
        drive(16'h0320, 16'h0320);
        bus(1'b1, `SBS_OFS_HYST, 32'h00000014);
        drive(16'h03B6, 16'h0384);
        drive(16'h03F2, 16'h0384);
        drive(16'h03FC, 16'h044C);
        drive(16'h03D9, 16'h044C);
        drive(16'h03D3, 16'h0384);
        bus(1'b1, `SBS_OFS_HYST, 32'h0);
        bus(1'b1, `SBS_OFS_SKIP1, 32'h0000047E);
        drive(16'h0438, 16'h04E2);
        drive(16'h042E, 16'h0384);
        bus(1'b1, `SBS_OFS_LIM_HI, 32'h000004B0);
        drive(16'h0424, 16'h04B0);
        drive(16'h0410, 16'h0384);
        bus(1'b1, `SBS_OFS_SKIP2, 32'h00001388);
        drive(16'h1388, 16'h1388);
        check({31'h0, skip_active}, 32'h0);
        bus(1'b0, `SBS_OFS_STAT, 32'h0);
        check(rd, 32'h00000730);
        bus(1'b1, `SBS_OFS_SLIP_FL, 32'h00000040);
        bus(1'b1, `SBS_OFS_GAIN, 32'h000000FF);
        bus(1'b1, `SBS_OFS_CTRL, 32'h00080000);
        @(posedge sys_clk);
        mode <= 3'h0;
        torque <= 16'sh1000;
        drive(16'h0BB8, 16'h0BB8);
        check({15'h0, meter}, 32'h0);
        @(posedge sys_clk);
        fdbk <= `SBS_FB_SENSORLESS;
        repeat (30) @(posedge sys_clk);
        check(in_rng(meter, 17'sh0003F, 17'sh00040), 32'h1);
        check(in_rng({1'b0, speed_out}, 17'sh00BF7, 17'sh00BF8), 32'h1);
        bus(1'b0, `SBS_OFS_METER, 32'h0);
        check(in_rng(rd[16:0], 17'sh0003F, 17'sh00040), 32'h1);
        @(posedge sys_clk);
        fdbk <= 3'h0;
        mode <= `SBS_MODE_VHZ;
        repeat (5) @(posedge sys_clk);
        check(in_rng(meter, 17'sh0003F, 17'sh00040), 32'h1);
        torque <= 16'sh0000;
        repeat (30) @(posedge sys_clk);
        check(in_rng(meter, 17'sh1FFFF, 17'sh00001), 32'h1);
        bus(1'b1, `SBS_OFS_CTRL, 32'h0);
        @(posedge sys_clk);
        torque <= 16'sh1000;
        repeat (10) @(posedge sys_clk);
        check({15'h0, meter}, 32'h0);
        bus(1'b1, `SBS_OFS_GAIN, 32'h00000001);
        bus(1'b1, `SBS_OFS_CTRL, 32'h00080000);
        repeat (20) @(posedge sys_clk);
        check(in_rng(meter, 17'sh00001, 17'sh00008), 32'h1);
        bus(1'b1, `SBS_OFS_CTRL, 32'h0);
        bus(1'b1, `SBS_OFS_GAIN, 32'h000000FF);
        bus(1'b1, `SBS_OFS_CTRL, 32'h00080000);
        repeat (5) @(posedge sys_clk);
        check(in_rng(meter, 17'sh0003C, 17'sh00040), 32'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
